//--- hw/acc_pkg.sv
// Contract
// - Low result register holds result bits 7..0.
// - High result register holds result bits 11..8 low, channel code high.
// - Stored channel code is the selection in force for that conversion.
// - Timing/power control bit 7 powers converter up when set.
// - Reference select bit one picks outside reference, zero the bandgap.
// - Divider bits 5..4 codes 00,01,10,11 divide core clock by 8,4,16,32.
// - Acquire field codes 00..11 give 1..4 converter clocks of tracking.
// - Timer trigger enable starts a conversion on each timer overflow.
// - Pin trigger enable starts a conversion on convert pin rising edge.
// - Serial enable forwards each result to the serial interface directly.
// - Continuous bit runs back to back conversions until software clears it.
// - Single bit runs one conversion and self-clears when results update.
// - Read-only busy flag set during conversion or calibration.
// - Calibration source bit zero internal voltages, one external voltages.
// - Calibration kind bit zero offset, one gain calibration.
// - Track phase then hold phase; final approximation value latched as result.
// - Internal sequencer runs approximation steps and phase timing alone.
package acc_pkg;

	// ==========================================================
	// Register addresses
	localparam logic [7:0] ADDR_CHANNEL_MODE = 8'hD8;
	localparam logic [7:0] ADDR_RESULT_LOW   = 8'hD9;
	localparam logic [7:0] ADDR_RESULT_HIGH  = 8'hDA;
	localparam logic [7:0] ADDR_TIMING_POWER = 8'hEF;
	localparam logic [7:0] ADDR_CALIBRATION  = 8'hF5;

	// ==========================================================
	// Reset values
	localparam logic [7:0] RST_CHANNEL_MODE = 8'h00;
	localparam logic [7:0] RST_TIMING_POWER = 8'h00;
	localparam logic [7:0] RST_CALIBRATION  = 8'h00;
	localparam logic [7:0] RST_RESULT       = 8'h00;

	// ==========================================================
	// Timing and power control fields
	localparam int POWER_BIT     = 7;
	localparam int OUTSIDE_REFERENCE_SELECT_BIT   = 6;
	localparam int DIV_HI_BIT    = 5;
	localparam int DIV_LO_BIT    = 4;
	localparam int ACQ_HI_BIT    = 3;
	localparam int ACQ_LO_BIT    = 2;
	localparam int TIMER_TRG_BIT = 1;
	localparam int PIN_TRG_BIT   = 0;

	// ==========================================================
	// Channel and mode control fields
	localparam int DONE_BIT   = 7;
	localparam int SERIAL_BIT = 6;
	localparam int CONT_BIT   = 5;
	localparam int SINGLE_BIT = 4;

	// ==========================================================
	// Calibration control fields
	localparam int BUSY_BIT     = 7;
	localparam int CAL_SRC_BIT  = 2;
	localparam int CAL_KIND_BIT = 1;
	localparam int CAL_START_BIT = 0;

	// ==========================================================
	// Converter clock divide ratios, indexed by divider code
	localparam logic [5:0] DIV_RATIO_00 = 6'h08;
	localparam logic [5:0] DIV_RATIO_01 = 6'h04;
	localparam logic [5:0] DIV_RATIO_10 = 6'h10;
	localparam logic [5:0] DIV_RATIO_11 = 6'h20;

	// ==========================================================
	// Conversion timing in converter clocks
	localparam logic [3:0] CONV_CLOCKS = 4'hF;
	localparam logic [3:0] SAR_STEPS   = 4'hC;

	// ==========================================================
	// Sequencer states
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_TRACK = 2'b01,
		ST_HOLD  = 2'b10
	} acc_state_t;

endpackage : acc_pkg

//--- hw/acc_clock_divider.sv
`timescale 1ns/100ps
// ==========================================================
// Converter clock tick generator
module acc_clock_divider
(
	input  wire logic       clk,
	input  wire logic       arst_n,
	input  wire logic       run,
	input  wire logic [1:0] divSel,
	output logic            tick
);

	logic [5:0] count_q;
	logic [5:0] count_d;
	logic       tick_q;
	logic       tick_d;
	logic [5:0] ratio;

	// Ratio lookup; codes are not monotonic, so a table is clearer than math.
	// divide ratios
	always_comb
	begin
		unique case (divSel)
			2'b00: ratio = acc_pkg::DIV_RATIO_00;
			2'b01: ratio = acc_pkg::DIV_RATIO_01;
			2'b10: ratio = acc_pkg::DIV_RATIO_10;
			2'b11: ratio = acc_pkg::DIV_RATIO_11;
		endcase
	end

	// The counter stops while powered down so the tick phase restarts cleanly.
	always_comb
	begin
		tick_d  = 1'b0;
		count_d = count_q;
		if (!run)
			count_d = 6'h00;
		else if (count_q >= ratio - 6'h01)
		begin
			count_d = 6'h00;
			tick_d  = 1'b1;
		end
		else
			count_d = count_q + 6'h01;
	end

	// Register stage.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			count_q <= 6'h00;
			tick_q  <= 1'b0;
		end
		else
		begin
			count_q <= count_d;
			tick_q  <= tick_d;
		end
	end

	assign tick = tick_q;

endmodule : acc_clock_divider

//--- hw/acc_conversion_control.sv
`timescale 1ns/100ps
// ==========================================================
// Conversion control, sequencing and result registers
module acc_conversion_control
(
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic [7:0]  sfrAddr,
	input  wire logic [7:0]  sfrWrData,
	input  wire logic        sfrWrite,
	input  wire logic        sfrRead,
	output logic      [7:0]  sfrRdData,
	input  wire logic        timerOverflow,
	input  wire logic        convert_start_pin_n,
	input  wire logic        irqVectorAck,
	input  wire logic        compHigh,
	output logic             powerUp,
	output logic             outside_reference_select,
	output logic             trackMode,
	output logic      [11:0] dacTrial,
	output logic      [3:0]  channelSel,
	output logic             calActive,
	output logic             calibration_source_select,
	output logic             calibration_kind_select,
	output logic      [11:0] calResult,
	output logic             conversion_done_flag,
	output logic      [15:0] serialWord,
	output logic             serialValid
);

	acc_pkg::acc_state_t state_q, state_d;
	logic [7:0]  ctrl1_q, ctrl1_d;
	logic [7:0]  ctrl2_q, ctrl2_d;
	logic [6:0]  ctrl3_q, ctrl3_d;
	logic [7:0]  resLow_q, resLow_d;
	logic [7:0]  resHigh_q, resHigh_d;
	logic [11:0] trial_q, trial_d;
	logic [11:0] mask_q, mask_d;
	logic [3:0]  step_q, step_d;
	logic [1:0]  acqCnt_q, acqCnt_d;
	logic [3:0]  chan_q, chan_d;
	logic        isCal_q, isCal_d;
	logic        pending_q, pending_d;
	logic        track_q, track_d;
	logic        busy_q, busy_d;
	logic [11:0] cal_q, cal_d;
	logic [15:0] serWord_q, serWord_d;
	logic        serValid_q, serValid_d;
	logic [7:0]  rd_q, rd_d;
	logic        pinS1_q, pinS2_q, pinS3_q, pinStable_q, pinStable_d;
	logic        pinRise;
	logic        tick;
	logic [11:0] kept;

	// Converter clock from the core clock, only while powered.
	acc_clock_divider u_div
	(
		.clk    (clk),
		.arst_n (arst_n),
		.run    (ctrl1_q[acc_pkg::POWER_BIT]),
		.divSel ({ctrl1_q[acc_pkg::DIV_HI_BIT], ctrl1_q[acc_pkg::DIV_LO_BIT]}),
		.tick   (tick)
	);

	// Pin filter: a level is accepted only when stages two and three agree.
	// pin edge
	always_comb
	begin
		pinStable_d = (pinS2_q == pinS3_q) ? pinS3_q : pinStable_q;
		pinRise     = (pinS2_q == pinS3_q) && pinS3_q && !pinStable_q;
	end

	// Approximation decision: keep the trial bit when the comparator says so.
	assign kept = compHigh ? trial_q : (trial_q & ~mask_q);

	// Main next-state logic: register writes first, hardware events after,
	// so hardware sets win over a same-cycle software clear.
	always_comb
	begin
		state_d    = state_q;
		ctrl1_d    = ctrl1_q;
		ctrl2_d    = ctrl2_q;
		ctrl3_d    = ctrl3_q;
		resLow_d   = resLow_q;
		resHigh_d  = resHigh_q;
		trial_d    = trial_q;
		mask_d     = mask_q;
		step_d     = step_q;
		acqCnt_d   = acqCnt_q;
		chan_d     = chan_q;
		isCal_d    = isCal_q;
		pending_d  = pending_q;
		track_d    = track_q;
		cal_d      = cal_q;
		serWord_d  = serWord_q;
		serValid_d = 1'b0;
		if (sfrWrite && sfrAddr == acc_pkg::ADDR_TIMING_POWER)
			ctrl1_d = sfrWrData;
		if (sfrWrite && sfrAddr == acc_pkg::ADDR_CHANNEL_MODE)
			ctrl2_d = sfrWrData;
		if (sfrWrite && sfrAddr == acc_pkg::ADDR_CALIBRATION)
			ctrl3_d = sfrWrData[6:0];
		if (irqVectorAck)
			ctrl2_d[acc_pkg::DONE_BIT] = 1'b0;
		if (timerOverflow && ctrl1_q[acc_pkg::TIMER_TRG_BIT])
			pending_d = 1'b1;
		if (pinRise && ctrl1_q[acc_pkg::PIN_TRG_BIT])
			pending_d = 1'b1;
		unique case (state_q)
			acc_pkg::ST_IDLE:
			begin
				if (tick && (ctrl3_q[acc_pkg::CAL_START_BIT]
					|| ctrl2_q[acc_pkg::SINGLE_BIT]
					|| ctrl2_q[acc_pkg::CONT_BIT] || pending_q))
				begin
					state_d   = acc_pkg::ST_TRACK;
					chan_d    = ctrl2_q[3:0];
					isCal_d   = ctrl3_q[acc_pkg::CAL_START_BIT];
					pending_d = 1'b0;
					acqCnt_d  = 2'b00;
					track_d   = 1'b1;
				end
			end
			acc_pkg::ST_TRACK:
			begin
				if (tick)
				begin
					if (acqCnt_q == {ctrl1_q[acc_pkg::ACQ_HI_BIT],
						ctrl1_q[acc_pkg::ACQ_LO_BIT]})
					begin
						state_d = acc_pkg::ST_HOLD;
						track_d = 1'b0;
						step_d  = 4'h0;
						trial_d = 12'h800;
						mask_d  = 12'h800;
					end
					else
						acqCnt_d = acqCnt_q + 2'b01;
				end
			end
			acc_pkg::ST_HOLD:
			begin
				if (tick)
				begin
					step_d = step_q + 4'h1;
					if (step_q < acc_pkg::SAR_STEPS)
					begin
						mask_d  = mask_q >> 1;
						trial_d = kept | (mask_q >> 1);
					end
					if (step_q == acc_pkg::CONV_CLOCKS - 4'h1)
					begin
						state_d = acc_pkg::ST_IDLE;
						if (isCal_q)
						begin
							cal_d = trial_q;
							ctrl3_d[acc_pkg::CAL_START_BIT] = 1'b0;
						end
						else
						begin
							resLow_d  = trial_q[7:0];
							resHigh_d = {chan_q, trial_q[11:8]};
							ctrl2_d[acc_pkg::DONE_BIT]   = 1'b1;
							ctrl2_d[acc_pkg::SINGLE_BIT] = 1'b0;
							if (ctrl2_q[acc_pkg::SERIAL_BIT])
							begin
								serWord_d  = {chan_q, trial_q};
								serValid_d = 1'b1;
							end
						end
					end
				end
			end
			default:
				state_d = acc_pkg::ST_IDLE;
		endcase
		if (!ctrl1_d[acc_pkg::POWER_BIT])
		begin
			state_d = acc_pkg::ST_IDLE;
			track_d = 1'b0;
		end
		busy_d = (state_d != acc_pkg::ST_IDLE);
	end

	// Registered read data; unmapped addresses read zero.
	always_comb
	begin
		rd_d = rd_q;
		if (sfrRead)
		begin
			unique case (sfrAddr)
				acc_pkg::ADDR_TIMING_POWER: rd_d = ctrl1_q;
				acc_pkg::ADDR_CHANNEL_MODE: rd_d = ctrl2_q;
				acc_pkg::ADDR_CALIBRATION:  rd_d = {busy_q, ctrl3_q};
				acc_pkg::ADDR_RESULT_LOW:   rd_d = resLow_q;
				acc_pkg::ADDR_RESULT_HIGH:  rd_d = resHigh_q;
				default:                    rd_d = 8'h00;
			endcase
		end
	end

	// Register stage for all state.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_q     <= acc_pkg::ST_IDLE;
			ctrl1_q     <= acc_pkg::RST_TIMING_POWER;
			ctrl2_q     <= acc_pkg::RST_CHANNEL_MODE;
			ctrl3_q     <= acc_pkg::RST_CALIBRATION[6:0];
			resLow_q    <= acc_pkg::RST_RESULT;
			resHigh_q   <= acc_pkg::RST_RESULT;
			trial_q     <= 12'h000;
			mask_q      <= 12'h000;
			step_q      <= 4'h0;
			acqCnt_q    <= 2'b00;
			chan_q      <= 4'h0;
			isCal_q     <= 1'b0;
			pending_q   <= 1'b0;
			track_q     <= 1'b0;
			busy_q      <= 1'b0;
			cal_q       <= 12'h000;
			serWord_q   <= 16'h0000;
			serValid_q  <= 1'b0;
			rd_q        <= 8'h00;
			pinS1_q     <= 1'b1;
			pinS2_q     <= 1'b1;
			pinS3_q     <= 1'b1;
			pinStable_q <= 1'b1;
		end
		else
		begin
			state_q     <= state_d;
			ctrl1_q     <= ctrl1_d;
			ctrl2_q     <= ctrl2_d;
			ctrl3_q     <= ctrl3_d;
			resLow_q    <= resLow_d;
			resHigh_q   <= resHigh_d;
			trial_q     <= trial_d;
			mask_q      <= mask_d;
			step_q      <= step_d;
			acqCnt_q    <= acqCnt_d;
			chan_q      <= chan_d;
			isCal_q     <= isCal_d;
			pending_q   <= pending_d;
			track_q     <= track_d;
			busy_q      <= busy_d;
			cal_q       <= cal_d;
			serWord_q   <= serWord_d;
			serValid_q  <= serValid_d;
			rd_q        <= rd_d;
			pinS1_q     <= convert_start_pin_n;
			pinS2_q     <= pinS1_q;
			pinS3_q     <= pinS2_q;
			pinStable_q <= pinStable_d;
		end
	end

	// Outputs straight from flip-flops.
	// reference select
	assign outside_reference_select  = ctrl1_q[acc_pkg::OUTSIDE_REFERENCE_SELECT_BIT];
	assign powerUp                   = ctrl1_q[acc_pkg::POWER_BIT];
	assign trackMode                 = track_q;
	assign dacTrial                  = trial_q;
	assign channelSel                = chan_q;
	assign calActive                 = isCal_q;
	assign calibration_source_select = ctrl3_q[acc_pkg::CAL_SRC_BIT];
	assign calibration_kind_select   = ctrl3_q[acc_pkg::CAL_KIND_BIT];
	assign calResult                 = cal_q;
	assign conversion_done_flag      = ctrl2_q[acc_pkg::DONE_BIT];
	assign serialWord                = serWord_q;
	assign serialValid               = serValid_q;
	assign sfrRdData                 = rd_q;

endmodule : acc_conversion_control

//--- tb/acc_analog_model.sv
`timescale 1ns/100ps
// ==========================================================
// Analog input model
module acc_analog_model
(
	input wire logic [11:0] level,
	input wire logic [11:0] dacTrial,
	output logic            compHigh
);
	// A held input at a fixed level; the trial bit stays while not above it.
	assign compHigh = (dacTrial <= level);
endmodule : acc_analog_model

//--- tb/acc_conversion_checker.sv
`timescale 1ns/100ps
// ==========================================================
// Port checks
module acc_conversion_checker
(
	input wire logic        clk,
	input wire logic        arst_n,
	input wire logic [7:0]  sfrAddr,
	input wire logic [7:0]  sfrWrData,
	input wire logic        sfrWrite,
	input wire logic        sfrRead,
	input wire logic [7:0]  sfrRdData,
	input wire logic        powerUp,
	input wire logic        outside_reference_select,
	input wire logic        trackMode,
	input wire logic [11:0] dacTrial,
	input wire logic [3:0]  channelSel,
	input wire logic        calibration_source_select,
	input wire logic        calibration_kind_select,
	input wire logic [15:0] serialWord,
	input wire logic        serialValid
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	// Control bits follow the write one cycle later.
	a_power_write: assert property (sfrWrite && sfrAddr == 8'hEF
		|=> powerUp == $past(sfrWrData[7])) else $error("power bit");
	a_ref_write: assert property (sfrWrite && sfrAddr == 8'hEF
		|=> outside_reference_select == $past(sfrWrData[6]))
		else $error("reference bit");
	a_src_write: assert property (sfrWrite && sfrAddr == 8'hF5
		|=> calibration_source_select == $past(sfrWrData[2]))
		else $error("cal source bit");
	a_kind_write: assert property (sfrWrite && sfrAddr == 8'hF5
		|=> calibration_kind_select == $past(sfrWrData[1]))
		else $error("cal kind bit");
	a_timing_read: assert property (sfrRead && !sfrWrite && sfrAddr == 8'hEF
		|=> sfrRdData[7:6] == {$past(powerUp),
		$past(outside_reference_select)}) else $error("timing readback");
	// A powered-down converter never stays in the track phase.
	a_power_abort: assert property (!powerUp |=> !trackMode)
		else $error("track while off");
	a_serial_chan: assert property (serialValid
		|-> serialWord[15:12] == channelSel) else $error("serial channel");
	// The approximation starts from the midpoint word.
	a_trial_start: assert property ($fell(trackMode) && powerUp
		|-> dacTrial == 12'h800) else $error("first trial");
endmodule : acc_conversion_checker

bind acc_conversion_control acc_conversion_checker chk (.clk, .arst_n,
	.sfrAddr, .sfrWrData, .sfrWrite, .sfrRead, .sfrRdData, .powerUp,
	.outside_reference_select, .trackMode, .dacTrial, .channelSel,
	.calibration_source_select, .calibration_kind_select, .serialWord,
	.serialValid);

//--- tb/acc_conversion_control_test.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin badCount++; \
	$display("mismatch %s exp %h got %h", n, e, g); end end
// ==========================================================
// Bench
module acc_conversion_control_test;
	logic        clk = 1'b0, arst_n = 1'b0, sfrWrite = 1'b0, sfrRead = 1'b0;
	logic        timerOverflow = 1'b0, irqVectorAck = 1'b0;
	logic        convert_start_pin_n = 1'b1;
	logic [7:0]  sfrAddr = 8'h00, sfrWrData = 8'h00, sfrRdData;
	logic        compHigh, powerUp, outside_reference_select, trackMode;
	logic        calibration_source_select, calibration_kind_select;
	logic        conversion_done_flag, serialValid;
	logic        calActive, ok;
	logic [3:0]  channelSel;
	logic [11:0] level = 12'h000, dacTrial, calResult;
	logic [15:0] serialWord, serLast;
	int          checks = 0, badCount = 0, serCount = 0, n, s;
	int          ratio [4] = '{8, 4, 16, 32};
	logic [7:0]  regs [6] = '{8'hD8, 8'hEF, 8'hF5, 8'hD9, 8'hDA, 8'h80};

	acc_conversion_control uut (.clk, .arst_n, .sfrAddr, .sfrWrData,
		.sfrWrite, .sfrRead, .sfrRdData, .timerOverflow,
		.convert_start_pin_n, .irqVectorAck, .compHigh, .powerUp,
		.outside_reference_select, .trackMode, .dacTrial, .channelSel,
		.calActive, .calibration_source_select, .calibration_kind_select,
		.calResult, .conversion_done_flag, .serialWord, .serialValid);
	acc_analog_model model (.level, .dacTrial, .compHigh);

	// Core clock.
	always #12.5 clk = ~clk;

	// Serial words are single-cycle pulses, so they are caught here.
	always @(posedge clk)
	begin
		if (serialValid === 1'b1)
		begin
			serCount++;
			serLast <= serialWord;
		end
	end

	// ==========================================================
	// Register access and waiting
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		sfrAddr <= a;
		sfrWrData <= d;
		sfrWrite <= 1'b1;
		@(posedge clk);
		sfrWrite <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		sfrAddr <= a;
		sfrRead <= 1'b1;
		@(posedge clk);
		sfrRead <= 1'b0;
		#1 `CHK("sfr read", e, sfrRdData)
	endtask : rd

	task automatic waitDone();
		n = 0;
		while (conversion_done_flag !== 1'b1 && n < 3000)
		begin
			@(posedge clk);
			#1 n++;
		end
		`CHK("done flag", 1'b1, conversion_done_flag)
	endtask : waitDone

	task automatic finalReport();
		$display("checks %0d mismatches %0d", checks, badCount);
		if (badCount == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : finalReport

	// Watchdog; the whole sequence needs under a fifth of this.
	initial
	begin
		#500000;
		badCount++;
		finalReport();
	end

	// ==========================================================
	// Test sequence
	initial
	begin
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		foreach (regs[i]) rd(regs[i], 8'h00);
		for (int c = 0; c < 4; c++)
		begin
			level = 12'h3C5 + 12'(c * 273);
			wr(8'hEF, 8'h80 | 8'(c * 20));
			wr(8'hD8, 8'h10 | 8'(c + 2));
			waitDone();
			// A sync tick, acquire plus one track ticks, then 15 hold ticks.
			ok = n >= (c + 16) * ratio[c] && n <= (c + 17) * ratio[c] + 3;
			`CHK("time", 1'b1, ok)
			rd(8'hD9, level[7:0]);
			rd(8'hDA, {4'(c + 2), level[11:8]});
			rd(8'hD8, 8'h80 | 8'(c + 2));
			@(posedge clk);
			irqVectorAck <= 1'b1;
			@(posedge clk);
			irqVectorAck <= 1'b0;
			#1 `CHK("done clear", 1'b0, conversion_done_flag)
		end
		// An overflow is ignored until the timer trigger is enabled.
		wr(8'hEF, 8'h80);
		@(posedge clk);
		timerOverflow <= 1'b1;
		@(posedge clk);
		timerOverflow <= 1'b0;
		repeat (300) @(posedge clk);
		#1 `CHK("no trigger", 1'b0, conversion_done_flag)
		wr(8'hEF, 8'h82);
		wr(8'hD8, 8'h47);
		s = serCount;
		timerOverflow <= 1'b1;
		@(posedge clk);
		timerOverflow <= 1'b0;
		waitDone();
		// The pulse is only counted at the edge after the done flag rises.
		@(posedge clk);
		#1 `CHK("serial word", {4'h7, level}, serLast)
		`CHK("serial count", s + 1, serCount)
		wr(8'hD8, 8'h00);
		#1 `CHK("soft clear", 1'b0, conversion_done_flag)
		// Pin trigger fires on the release of the pin.
		level = 12'h5A3;
		wr(8'hEF, 8'h81);
		convert_start_pin_n <= 1'b0;
		repeat (10) @(posedge clk);
		convert_start_pin_n <= 1'b1;
		waitDone();
		rd(8'hD9, 8'hA3);
		s = serCount;
		wr(8'hD8, 8'h61);
		repeat (600) @(posedge clk);
		#1 `CHK("continuous", 1'b1, serCount >= s + 3)
		wr(8'hD8, 8'h40);
		repeat (200) @(posedge clk);
		s = serCount;
		repeat (400) @(posedge clk);
		`CHK("stopped", s, serCount)
		// Long track phase, then power off in mid-conversion.
		wr(8'hEF, 8'hBC);
		wr(8'hD8, 8'h12);
		repeat (60) @(posedge clk);
		rd(8'hF5, 8'h80);
		`CHK("tracking", 1'b1, trackMode)
		`CHK("channel", 4'h2, channelSel)
		`CHK("not cal", 1'b0, calActive)
		wr(8'hEF, 8'h40);
		rd(8'hF5, 8'h00);
		`CHK("aborted", 1'b0, trackMode)
		`CHK("outside ref", 1'b1, outside_reference_select)
		wr(8'hD8, 8'h00);
		level = 12'h7E1;
		wr(8'hEF, 8'h80);
		wr(8'hF5, 8'h07);
		#1 `CHK("cal source", 1'b1, calibration_source_select)
		`CHK("cal kind", 1'b1, calibration_kind_select)
		repeat (400) @(posedge clk);
		rd(8'hF5, 8'h06);
		`CHK("cal result", level, calResult)
		`CHK("cal active", 1'b1, calActive)
		wr(8'hF5, 8'h80);
		rd(8'hF5, 8'h00);
		finalReport();
	end
endmodule : acc_conversion_control_test
